//--- cpu_exec_pkg.sv
// Constants, opcode patterns and carrier types of the execute core.
// Assumes a single instruction clock and a plain register port.
package cpu_exec_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_W = 15;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam int BANK_W = 5;
  localparam int LATCH_W = 7;
  localparam int BUS_ADDR_W = 4;
  localparam int BUS_DATA_W = 16;

  // ==========================================================================
  // Register port map (word indices)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ACC = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_PC = 4'h3;
  localparam logic [3:0] REG_BANK_LATCH = 4'h4;
  localparam logic [3:0] REG_PTR0 = 4'h5;
  localparam logic [3:0] REG_PTR1 = 4'h6;
  localparam logic [3:0] REG_WDT = 4'h7;
  localparam logic [3:0] REG_STACK_TOP = 4'h8;
  localparam logic [3:0] REG_DATA_ADDR = 4'h9;
  localparam logic [3:0] REG_DATA_WIN = 4'ha;

  // Field positions.
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_C_BIT = 0;
  localparam int STAT_Z_BIT = 1;
  localparam int STAT_PD_BIT = 2;
  localparam int STAT_TO_BIT = 3;
  localparam int LATCH_LSB = 8;

  // Reset values.
  localparam logic RUN_RST = 1'b0;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  localparam logic [7:0] ACC_RST = 8'h00;

  // ==========================================================================
  // Instruction patterns: a word matches when (word & mask) == pat.
  typedef struct packed {
    logic [13:0] mask;
    logic [13:0] pat;
  } opc_t;

  localparam opc_t OP_CALL = '{14'h3800, 14'h2000};
  localparam opc_t OP_UNCONDITIONAL_JUMP = '{14'h3800, 14'h2800};
  localparam opc_t OP_ACCUMULATOR_INDEXED_INVOKE = '{14'h3fff, 14'h000a};
  localparam opc_t OP_WATCHDOG_CLEAR_OP = '{14'h3fff, 14'h0064};
  localparam opc_t OP_REGISTER_INVERT_OP = '{14'h3f00, 14'h0900};
  localparam opc_t OP_REGISTER_ZERO_OP = '{14'h3f80, 14'h0180};
  localparam opc_t OP_ACCUMULATOR_ZERO_OP = '{14'h3f80, 14'h0100};
  localparam opc_t OP_REGISTER_DECREMENT_OP = '{14'h3f00, 14'h0300};
  localparam opc_t OP_DECREMENT_SKIP_ZERO_OP = '{14'h3f00, 14'h0b00};
  localparam opc_t OP_REGISTER_INCREMENT_OP = '{14'h3f00, 14'h0a00};
  localparam opc_t OP_INCREMENT_SKIP_ZERO_OP = '{14'h3f00, 14'h0f00};
  localparam opc_t OP_OR_LITERAL_OP = '{14'h3f00, 14'h3800};
  localparam opc_t OP_OR_REGISTER_OP = '{14'h3f00, 14'h0400};
  localparam opc_t OP_LOGICAL_SHIFT_LEFT_OP = '{14'h3f00, 14'h3500};
  localparam opc_t OP_LOGICAL_SHIFT_RIGHT_OP = '{14'h3f00, 14'h3600};
  localparam opc_t OP_REGISTER_COPY_OP = '{14'h3f00, 14'h0800};
  localparam opc_t OP_LOADIND = '{14'h3ff8, 14'h0010};
  localparam opc_t OP_STOREIND = '{14'h3ff8, 14'h0018};
  localparam opc_t OP_LOADIDX = '{14'h3f80, 14'h3f00};
  localparam opc_t OP_STOREIDX = '{14'h3f80, 14'h3f80};
  localparam opc_t OP_BANK_LITERAL_OP = '{14'h3fe0, 14'h0020};
  localparam opc_t OP_HIGH_LATCH_LITERAL_OP = '{14'h3f80, 14'h3180};
  localparam opc_t OP_ACCUMULATOR_LITERAL_OP = '{14'h3f00, 14'h3000};
  localparam opc_t OP_ACCUMULATOR_STORE_OP = '{14'h3f80, 14'h0080};

  // Pointer update modes and the two indirect-access locations.
  localparam logic [1:0] MODE_PREINC = 2'b00;
  localparam logic [1:0] MODE_PREDEC = 2'b01;
  localparam logic [1:0] MODE_POSTINC = 2'b10;
  localparam logic [1:0] MODE_POSTDEC = 2'b11;
  localparam logic [6:0] INDIRECT0_LOC = 7'h00;
  localparam logic [6:0] INDIRECT1_LOC = 7'h01;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [BUS_ADDR_W-1:0] addr;
    logic [BUS_DATA_W-1:0] wrData;
    logic wrStb;
    logic rdStb;
  } bus_req_t;

  typedef enum logic [1:0] {ST_RUN, ST_FLUSH, ST_WAIT} exec_state_t;

endpackage

//--- cpu_instruction_execute_subset.sv
// Execute core for a subset of a 14-bit instruction set with data memory.
// Assumes program memory answers progAddr in the same cycle (async ROM).
//
// What this block does
// - Invoke pushes next address, jumps to literal with latch bits 6:3.
// - Watchdog clear zeroes counter and prescaler, sets both status flags.
// - Accumulator invoke pushes next address, jumps to latch and accumulator.
// - Invert register, route by destination bit, update zero flag.
// - Register zero writes zero and sets the zero flag.
// - Accumulator zero writes zero and sets the zero flag.
// - Decrement register, route by destination bit, update zero flag.
// - Increment register, route by destination bit, update zero flag.
// - Skip forms keep flags, and a zero result replaces the next op.
// - Jump loads literal with latch bits 6:3, flags kept, two cycles.
// - OR accumulator with literal or register, update zero flag.
// - Left shift: bit 7 to carry, zero into bit 0, route result.
// - Right shift: bit 0 to carry, zero into bit 7, route result.
// - Register copy to accumulator or itself, update zero flag.
// - Mode field selects pre/post increment/decrement; loads update zero flag.
// - Indexed form adds signed offset, pointer left unchanged.
// - Indirect-access locations map to the address held in a pointer.
// - Pointer arithmetic wraps modulo sixteen bits.
// - Bank literal loads five bits into bank select, no flags.
// - High latch literal loads seven bits, no flags.
// - Accumulator literal loads eight bits in one cycle, no flags.
// - Accumulator store copies to the register in one cycle.
// - Branches and taken skips take two cycles, the second idle.
// - Indirect access through a pointer with MSB set adds a cycle.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module cpu_instruction_execute_subset #(
  parameter int DATA_DEPTH = 256,
  parameter int STACK_DEPTH = 16,
  parameter int WDT_PRESCALE = 64,
  parameter int WDT_W = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic [cpu_exec_pkg::PC_W-1:0] progAddr,
  input wire logic [cpu_exec_pkg::INSTR_W-1:0] instrWord,
  input wire cpu_exec_pkg::bus_req_t busReq,
  output logic [cpu_exec_pkg::BUS_DATA_W-1:0] busRdData
);

  localparam int IDX_W = $clog2(DATA_DEPTH);
  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int PRE_W = $clog2(WDT_PRESCALE);

  // ==========================================================================
  // Elaboration checks
  if (DATA_DEPTH < 2 || DATA_DEPTH > 65536 ||
      (DATA_DEPTH & (DATA_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DATA_DEPTH must be a power of two from 2 to 65536");
  end
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_sp
    $error("STACK_DEPTH must be a power of two of at least 2");
  end
  if (WDT_PRESCALE < 2 || WDT_W < 1 || WDT_W > 16) begin : g_bad_wdt
    $error("WDT_PRESCALE must be at least 2 and WDT_W within 1 to 16");
  end

  function automatic logic match(input logic [13:0] w,
                                 input cpu_exec_pkg::opc_t op);
    match = (w & op.mask) == op.pat;
  endfunction

  // ==========================================================================
  // State
  logic [cpu_exec_pkg::PC_W-1:0] pc_r, pcNxt;
  logic [cpu_exec_pkg::PC_W-1:0] stack_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [7:0] dataMem [DATA_DEPTH];
  logic [7:0] acc_r;
  logic zFlag_r, cFlag_r, toFlag_r, pdFlag_r, run_r;
  logic [cpu_exec_pkg::BANK_W-1:0] bank_r;
  logic [cpu_exec_pkg::LATCH_W-1:0] latch_r;
  logic [cpu_exec_pkg::PTR_W-1:0] ptr0_r, ptr1_r;
  logic [cpu_exec_pkg::PTR_W-1:0] dataAddr_r;
  logic [PRE_W-1:0] wdtPre_r;
  logic [WDT_W-1:0] wdtCount_r;
  logic [cpu_exec_pkg::BUS_DATA_W-1:0] rdData_r, rdNxt;
  cpu_exec_pkg::exec_state_t state_r, stateNxt;

  // ==========================================================================
  // Decode
  wire logic [13:0] ir = instrWord;
  wire logic isCall = match(ir, cpu_exec_pkg::OP_CALL);
  wire logic isGoto = match(ir, cpu_exec_pkg::OP_UNCONDITIONAL_JUMP);
  wire logic isCallw = match(ir, cpu_exec_pkg::OP_ACCUMULATOR_INDEXED_INVOKE);
  wire logic isClrwdt = match(ir, cpu_exec_pkg::OP_WATCHDOG_CLEAR_OP);
  wire logic isComf = match(ir, cpu_exec_pkg::OP_REGISTER_INVERT_OP);
  wire logic isClrf = match(ir, cpu_exec_pkg::OP_REGISTER_ZERO_OP);
  wire logic isClrw = match(ir, cpu_exec_pkg::OP_ACCUMULATOR_ZERO_OP);
  wire logic isDecf = match(ir, cpu_exec_pkg::OP_REGISTER_DECREMENT_OP);
  wire logic isDecfsz = match(ir, cpu_exec_pkg::OP_DECREMENT_SKIP_ZERO_OP);
  wire logic isIncf = match(ir, cpu_exec_pkg::OP_REGISTER_INCREMENT_OP);
  wire logic isIncfsz = match(ir, cpu_exec_pkg::OP_INCREMENT_SKIP_ZERO_OP);
  wire logic isIorlw = match(ir, cpu_exec_pkg::OP_OR_LITERAL_OP);
  wire logic isIorwf = match(ir, cpu_exec_pkg::OP_OR_REGISTER_OP);
  wire logic isLslf = match(ir, cpu_exec_pkg::OP_LOGICAL_SHIFT_LEFT_OP);
  wire logic isLsrf = match(ir, cpu_exec_pkg::OP_LOGICAL_SHIFT_RIGHT_OP);
  wire logic isMovf = match(ir, cpu_exec_pkg::OP_REGISTER_COPY_OP);
  wire logic isLoadInd = match(ir, cpu_exec_pkg::OP_LOADIND);
  wire logic isStoreInd = match(ir, cpu_exec_pkg::OP_STOREIND);
  wire logic isLoadIdx = match(ir, cpu_exec_pkg::OP_LOADIDX);
  wire logic isStoreIdx = match(ir, cpu_exec_pkg::OP_STOREIDX);
  wire logic isMovlb = match(ir, cpu_exec_pkg::OP_BANK_LITERAL_OP);
  wire logic isMovlp = match(ir, cpu_exec_pkg::OP_HIGH_LATCH_LITERAL_OP);
  wire logic isMovlw = match(ir, cpu_exec_pkg::OP_ACCUMULATOR_LITERAL_OP);
  wire logic isMovwf = match(ir, cpu_exec_pkg::OP_ACCUMULATOR_STORE_OP);

  wire logic destReg = ir[7];
  wire logic [6:0] fLoc = ir[6:0];
  wire logic [1:0] mode = ir[1:0];
  wire logic isModeForm = isLoadInd | isStoreInd;
  wire logic isIdxForm = isLoadIdx | isStoreIdx;
  wire logic isIndOp = isModeForm | isIdxForm;
  wire logic usesF = isComf | isClrf | isDecf | isDecfsz | isIncf |
                     isIncfsz | isIorwf | isLslf | isLsrf | isMovf | isMovwf;
  wire logic indirectF = usesF & ((fLoc == cpu_exec_pkg::INDIRECT0_LOC) |
                                  (fLoc == cpu_exec_pkg::INDIRECT1_LOC));

  // ==========================================================================
  // Addressing
  // The indirect-access locations hold nothing; they redirect.
  wire logic ptrSel = isModeForm ? ir[2] : (isIdxForm ? ir[6] : fLoc[0]);
  wire logic [15:0] ptrVal = ptrSel ? ptr1_r : ptr0_r;
  wire logic [15:0] ptrInc = ptrVal + 16'h0001;
  wire logic [15:0] ptrDec = ptrVal - 16'h0001;
  wire logic [15:0] idxOff = {{10{ir[5]}}, ir[5:0]};
  wire logic [15:0] ptrIdx = ptrVal + idxOff;
  wire logic [15:0] modeAddr =
    (mode == cpu_exec_pkg::MODE_PREINC) ? ptrInc :
    (mode == cpu_exec_pkg::MODE_PREDEC) ? ptrDec : ptrVal;
  wire logic [15:0] ptrNew = mode[0] ? ptrDec : ptrInc;
  wire logic [15:0] effAddr =
    isModeForm ? modeAddr :
    isIdxForm ? ptrIdx :
    indirectF ? ptrVal : {4'h0, bank_r, fLoc};
  wire logic [IDX_W-1:0] memIdx = effAddr[IDX_W-1:0];
  wire logic [7:0] fVal = dataMem[memIdx];
  wire logic needExtra = (isIndOp | indirectF) & ptrVal[15];

  // ==========================================================================
  // Result path
  logic [7:0] res;
  logic wAcc, wMem, zUpd, cUpd, cVal;

  always_comb begin
    res = fVal;
    wAcc = 1'b0;
    wMem = 1'b0;
    zUpd = 1'b0;
    cUpd = 1'b0;
    cVal = cFlag_r;
    if (isComf) begin
      res = ~fVal;
      zUpd = 1'b1;
    end else if (isClrf | isClrw) begin
      res = 8'h00;
      zUpd = 1'b1;
    end else if (isDecf | isDecfsz) begin
      res = fVal - 8'h01;
      zUpd = isDecf;
    end else if (isIncf | isIncfsz) begin
      res = fVal + 8'h01;
      zUpd = isIncf;
    end else if (isIorlw) begin
      res = acc_r | ir[7:0];
      zUpd = 1'b1;
    end else if (isIorwf) begin
      res = acc_r | fVal;
      zUpd = 1'b1;
    end else if (isLslf) begin
      res = {fVal[6:0], 1'b0};
      cVal = fVal[7];
      cUpd = 1'b1;
      zUpd = 1'b1;
    end else if (isLsrf) begin
      res = {1'b0, fVal[7:1]};
      cVal = fVal[0];
      cUpd = 1'b1;
      zUpd = 1'b1;
    end else if (isMovf | isLoadInd | isLoadIdx) begin
      zUpd = 1'b1;
    end else if (isMovwf | isStoreInd | isStoreIdx) begin
      res = acc_r;
    end else if (isMovlw) begin
      res = ir[7:0];
    end
    if (isClrw | isIorlw | isMovlw | isLoadInd | isLoadIdx) begin
      wAcc = 1'b1;
    end else if (isClrf | isMovwf | isStoreInd | isStoreIdx) begin
      wMem = 1'b1;
    end else if (usesF) begin
      wAcc = ~destReg;
      wMem = destReg;
    end
  end

  // ==========================================================================
  // Sequencing
  wire logic branch = isCall | isGoto | isCallw;
  wire logic skipTaken = (isDecfsz | isIncfsz) & (res == 8'h00);
  wire logic exec = run_r & ((state_r == cpu_exec_pkg::ST_RUN & ~needExtra) |
                             state_r == cpu_exec_pkg::ST_WAIT);
  wire logic push = exec & (isCall | isCallw);
  wire logic [14:0] retAddr = pc_r + 15'h0001;
  wire logic [14:0] jumpAddr = {latch_r[6:3], ir[10:0]};
  wire logic [14:0] accAddr = {latch_r, acc_r};
  wire logic [14:0] stackTop = stack_r[sp_r - SP_W'(1)];

  always_comb begin
    pcNxt = pc_r;
    if (exec) begin
      if (isCall | isGoto) begin
        pcNxt = jumpAddr;
      end else if (isCallw) begin
        pcNxt = accAddr;
      end else if (skipTaken) begin
        pcNxt = pc_r + 15'h0002;
      end else begin
        pcNxt = retAddr;
      end
    end
  end

  // The idle cycle after a branch or a taken skip stands for the
  // discarded instruction, so the target needs no pipeline flush logic.
  always_comb begin
    stateNxt = state_r;
    case (state_r)
      cpu_exec_pkg::ST_RUN: begin
        if (run_r && needExtra) begin
          stateNxt = cpu_exec_pkg::ST_WAIT;
        end else if (exec && (branch || skipTaken)) begin
          stateNxt = cpu_exec_pkg::ST_FLUSH;
        end
      end
      cpu_exec_pkg::ST_WAIT: begin
        if (run_r) begin
          stateNxt = skipTaken ? cpu_exec_pkg::ST_FLUSH : cpu_exec_pkg::ST_RUN;
        end
      end
      cpu_exec_pkg::ST_FLUSH: begin
        if (run_r) begin
          stateNxt = cpu_exec_pkg::ST_RUN;
        end
      end
      default: stateNxt = cpu_exec_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= cpu_exec_pkg::ST_RUN;
      pc_r <= '0;
      sp_r <= '0;
    end else begin
      state_r <= stateNxt;
      pc_r <= pcNxt;
      if (push) begin
        sp_r <= sp_r + SP_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      stack_r[sp_r] <= retAddr;
    end
  end

  // ==========================================================================
  // Accumulator, flags and literal registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_r <= cpu_exec_pkg::ACC_RST;
      zFlag_r <= 1'b0;
      cFlag_r <= 1'b0;
    end else if (exec) begin
      if (wAcc) begin
        acc_r <= res;
      end
      if (zUpd) begin
        zFlag_r <= (res == 8'h00);
      end
      if (cUpd) begin
        cFlag_r <= cVal;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bank_r <= '0;
      latch_r <= '0;
    end else if (exec) begin
      if (isMovlb) begin
        bank_r <= ir[4:0];
      end
      if (isMovlp) begin
        latch_r <= ir[6:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr0_r <= '0;
      ptr1_r <= '0;
    end else if (exec && isModeForm) begin
      if (ptrSel) begin
        ptr1_r <= ptrNew;
      end else begin
        ptr0_r <= ptrNew;
      end
    end
  end

  // Software may only write data memory while the core is halted, which
  // keeps a single write port and avoids a write collision.
  wire logic busWr = busReq.wrStb;
  wire logic memBusWr = busWr & ~run_r &
                        (busReq.addr == cpu_exec_pkg::REG_DATA_WIN);

  always_ff @(posedge clk_sys) begin
    if (exec && wMem) begin
      dataMem[memIdx] <= res;
    end else if (memBusWr) begin
      dataMem[dataAddr_r[IDX_W-1:0]] <= busReq.wrData[7:0];
    end
  end

  // ==========================================================================
  // Watchdog
  wire logic wdtClr = exec & isClrwdt;
  wire logic preWrap = wdtPre_r == PRE_W'(WDT_PRESCALE - 1);
  wire logic wdtExpire = preWrap & (&wdtCount_r);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wdtPre_r <= '0;
      wdtCount_r <= '0;
      toFlag_r <= cpu_exec_pkg::TO_RST;
      pdFlag_r <= cpu_exec_pkg::PD_RST;
    end else if (wdtClr) begin
      wdtPre_r <= '0;
      wdtCount_r <= '0;
      toFlag_r <= 1'b1;
      pdFlag_r <= 1'b1;
    end else begin
      wdtPre_r <= preWrap ? '0 : wdtPre_r + PRE_W'(1);
      if (preWrap) begin
        wdtCount_r <= wdtCount_r + WDT_W'(1);
      end
      if (wdtExpire) begin
        toFlag_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Register port
  wire logic [15:0] statusWord = {12'h000, toFlag_r, pdFlag_r,
                                  zFlag_r, cFlag_r};

  always_comb begin
    rdNxt = '0;
    case (busReq.addr)
      cpu_exec_pkg::REG_CTRL: rdNxt = {15'h0000, run_r};
      cpu_exec_pkg::REG_ACC: rdNxt = {8'h00, acc_r};
      cpu_exec_pkg::REG_STATUS: rdNxt = statusWord;
      cpu_exec_pkg::REG_PC: rdNxt = {1'b0, pc_r};
      cpu_exec_pkg::REG_BANK_LATCH: rdNxt = {1'b0, latch_r, 3'h0, bank_r};
      cpu_exec_pkg::REG_PTR0: rdNxt = ptr0_r;
      cpu_exec_pkg::REG_PTR1: rdNxt = ptr1_r;
      cpu_exec_pkg::REG_WDT: rdNxt = 16'(wdtCount_r);
      cpu_exec_pkg::REG_STACK_TOP: rdNxt = {1'b0, stackTop};
      cpu_exec_pkg::REG_DATA_ADDR: rdNxt = dataAddr_r;
      cpu_exec_pkg::REG_DATA_WIN:
        rdNxt = {8'h00, dataMem[dataAddr_r[IDX_W-1:0]]};
      default: rdNxt = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_r <= cpu_exec_pkg::RUN_RST;
      dataAddr_r <= '0;
      rdData_r <= '0;
    end else begin
      rdData_r <= busReq.rdStb ? rdNxt : '0;
      if (busWr && busReq.addr == cpu_exec_pkg::REG_CTRL) begin
        run_r <= busReq.wrData[cpu_exec_pkg::CTRL_RUN_BIT];
      end
      if (busWr && busReq.addr == cpu_exec_pkg::REG_DATA_ADDR) begin
        dataAddr_r <= busReq.wrData;
      end
    end
  end

  assign progAddr = pc_r;
  assign busRdData = rdData_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_invoke_target: assert property (exec && isCall |=>
    pc_r == $past(jumpAddr) && stackTop == $past(retAddr))
    else $error("invoke target or return address wrong");
  chk_wdt_clear: assert property (wdtClr |=>
    wdtCount_r == '0 && wdtPre_r == '0 && toFlag_r && pdFlag_r)
    else $error("watchdog clear incomplete");
  chk_acc_invoke: assert property (exec && isCallw |=>
    pc_r == $past(accAddr) && state_r == cpu_exec_pkg::ST_FLUSH)
    else $error("accumulator invoke wrong");
  chk_reg_zero: assert property (exec && isClrf |=> zFlag_r)
    else $error("register zero left zero flag clear");
  chk_acc_zero: assert property (exec && isClrw |=>
    acc_r == 8'h00 && zFlag_r)
    else $error("accumulator zero wrong");
  chk_skip_idle: assert property (exec && skipTaken |=>
    state_r == cpu_exec_pkg::ST_FLUSH && zFlag_r == $past(zFlag_r) ##1
    pc_r == $past(pc_r, 2) + 15'h0002)
    else $error("skip did not idle one cycle");
  chk_jump_flags: assert property (exec && isGoto |=>
    pc_r == $past(jumpAddr) && $stable(zFlag_r) && $stable(cFlag_r))
    else $error("jump target or flags wrong");
  chk_shift_carry: assert property (exec && isLslf |=>
    cFlag_r == $past(fVal[7]))
    else $error("left shift carry wrong");
  chk_ptr_wrap: assert property (exec && isModeForm && !ptrSel &&
    ptr0_r == 16'hffff && !mode[0] |=> ptr0_r == 16'h0000)
    else $error("pointer did not wrap");
  chk_bank_load: assert property (exec && isMovlb |=>
    bank_r == $past(ir[4:0]) && $stable(zFlag_r))
    else $error("bank literal not loaded");
  chk_extra_cycle: assert property (run_r && needExtra &&
    state_r == cpu_exec_pkg::ST_RUN |=> state_r == cpu_exec_pkg::ST_WAIT &&
    $stable(pc_r))
    else $error("pointer MSB did not add a cycle");

  cov_invoke: cover property (exec && isCall ##2 exec);
  cov_skip: cover property (exec && skipTaken);
  cov_extra: cover property (state_r == cpu_exec_pkg::ST_WAIT && exec);
  cov_ind_load: cover property (exec && isLoadInd);

endmodule // cpu_instruction_execute_subset

`default_nettype wire

//--- prog_rom.sv
// Program memory model seen by the execute core.
// Assumes the bench fills it before the core is started.
`timescale 1ns/10ps
`default_nettype none

module prog_rom (
  input wire logic [cpu_exec_pkg::PC_W-1:0] progAddr,
  output logic [cpu_exec_pkg::INSTR_W-1:0] instrWord
);
  // ==========================================================================
  // Storage
  // Only 4096 words are held to keep the model small; higher addresses
  // alias, so programs must stay below that.
  logic [13:0] mem [0:4095];

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 14'h0000;
    end
  end

  // Answers in the same cycle, as an asynchronous ROM does.
  assign instrWord = mem[progAddr[11:0]];
endmodule // prog_rom
`default_nettype wire

//--- test_cpu_instruction_execute_subset.sv
// Self-checking bench for the execute core: runs two short programs.
// Assumes the core is halted after reset and started through CTRL.
`timescale 1ns/10ps
`default_nettype none

module test_cpu_instruction_execute_subset;
  // ==========================================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  cpu_exec_pkg::bus_req_t busReq = '0;
  logic [14:0] progAddr;
  logic [13:0] instrWord;
  logic [15:0] busRdData;
  int err_total = 0;
  int check_count = 0;
  int n;
  // Second program, laid over the self-loop once phase one is checked.
  logic [13:0] progB [16] = '{14'h0021, 14'h00a5, 14'h35a5, 14'h0325,
    14'h04a5, 14'h0825, 14'h0019, 14'h001a, 14'h0100, 14'h3f3f, 14'h00a6,
    14'h0100, 14'h0f25, 14'h0081, 14'h3fc2, 14'h000a};

  always #2 clk_sys = ~clk_sys;

  cpu_instruction_execute_subset cpu_instruction_execute_subset_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .progAddr(progAddr),
    .instrWord(instrWord),
    .busReq(busReq),
    .busRdData(busRdData)
  );

  prog_rom prog_rom_inst (
    .progAddr(progAddr),
    .instrWord(instrWord)
  );

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    busReq <= '0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    busReq <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    busReq <= '0;
    #1 chk(busRdData, exp);
  endtask

  // Reads one data location through the address and window registers.
  task automatic peek(input logic [15:0] a, input logic [15:0] exp);
    wr(cpu_exec_pkg::REG_DATA_ADDR, a);
    rd(cpu_exec_pkg::REG_DATA_WIN, exp);
  endtask

  task automatic test_done;
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    prog_rom_inst.mem[12'h000] = 14'h305a;
    prog_rom_inst.mem[12'h001] = 14'h3881;
    prog_rom_inst.mem[12'h002] = 14'h00a0;
    prog_rom_inst.mem[12'h003] = 14'h36a0;
    prog_rom_inst.mem[12'h004] = 14'h0920;
    prog_rom_inst.mem[12'h005] = 14'h3188;
    prog_rom_inst.mem[12'h006] = 14'h2810;
    prog_rom_inst.mem[12'h810] = 14'h01a1;
    prog_rom_inst.mem[12'h811] = 14'h0aa1;
    prog_rom_inst.mem[12'h812] = 14'h0ba1;
    prog_rom_inst.mem[12'h813] = 14'h30ff;
    prog_rom_inst.mem[12'h814] = 14'h0064;
    prog_rom_inst.mem[12'h815] = 14'h2100;
    prog_rom_inst.mem[12'h900] = 14'h2900;
    rd(cpu_exec_pkg::REG_STATUS, 16'h000c);
    wr(cpu_exec_pkg::REG_CTRL, 16'h0001);
    #1 n = 0;
    while (progAddr !== 15'h0001 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    n = 0;
    while (progAddr !== 15'h0900 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(16'(n), 16'h000d);
    wr(cpu_exec_pkg::REG_CTRL, 16'h0000);
    rd(cpu_exec_pkg::REG_ACC, 16'h0092);
    rd(cpu_exec_pkg::REG_STATUS, 16'h000d);
    rd(cpu_exec_pkg::REG_PC, 16'h0900);
    rd(cpu_exec_pkg::REG_STACK_TOP, 16'h0816);
    rd(cpu_exec_pkg::REG_BANK_LATCH, 16'h0800);
    wr(cpu_exec_pkg::REG_DATA_ADDR, 16'h0020);
    rd(cpu_exec_pkg::REG_DATA_WIN, 16'h006d);
    wr(cpu_exec_pkg::REG_DATA_ADDR, 16'h0021);
    rd(cpu_exec_pkg::REG_DATA_WIN, 16'h0000);
    rd(4'hf, 16'h0000);
    // Phase two: the halted core restarts in its idle cycle at 0x900.
    for (int i = 0; i < 16; i++) begin
      prog_rom_inst.mem[12'h900 + i] = progB[i];
    end
    prog_rom_inst.mem[12'h828] = 14'h2828;
    wr(cpu_exec_pkg::REG_CTRL, 16'h0001);
    #1 n = 0;
    while (progAddr !== 15'h0828 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(16'(n), 16'h0012);
    wr(cpu_exec_pkg::REG_CTRL, 16'h0000);
    rd(cpu_exec_pkg::REG_ACC, 16'h0028);
    rd(cpu_exec_pkg::REG_STATUS, 16'h000f);
    rd(cpu_exec_pkg::REG_PC, 16'h0828);
    rd(cpu_exec_pkg::REG_STACK_TOP, 16'h0910);
    rd(cpu_exec_pkg::REG_BANK_LATCH, 16'h0801);
    rd(cpu_exec_pkg::REG_PTR0, 16'h0000);
    rd(cpu_exec_pkg::REG_PTR1, 16'h0000);
    peek(16'h00a5, 16'h0027);
    peek(16'h00a6, 16'h0027);
    peek(16'h00ff, 16'h0027);
    peek(16'h0000, 16'h0028);
    peek(16'h0002, 16'h0028);
    test_done();
  end

  // The program needs well under a thousand cycles.
  initial begin
    #20000;
    err_total++;
    test_done();
  end
endmodule // test_cpu_instruction_execute_subset
`default_nettype wire
